// file: shared/kbscn_consts.vh
// Constants for the keyboard, switch, LED and slider scanner.
`ifndef KBSCN_CONSTS_VH
`define KBSCN_CONSTS_VH

// Register byte addresses.
`define KBS_A_CTRL 8'h00
`define KBS_A_STAT 8'h04
`define KBS_A_MASK 8'h08
`define KBS_A_INDEX 8'h0c
`define KBS_A_SW 8'h10
`define KBS_A_LED 8'h14
`define KBS_A_KEYS 8'h18
`define KBS_A_VEL 8'h1c
`define KBS_A_SLD 8'h20

// Control register fields.
`define KBS_CTRL_W 5
`define KBS_CTRL_RST 5'h00
`define KBS_C_EN 0
`define KBS_C_ROW4 1
`define KBS_C_BRNC 2
`define KBS_C_BRCC 3
`define KBS_C_MKCC 4

// Event bits, shared by status and mask.
`define KBS_EV_W 4
`define KBS_EV_RST 4'h0
`define KBS_EV_KON 0
`define KBS_EV_KOFF 1
`define KBS_EV_SW 2
`define KBS_EV_FRM 3

// Index register fields.
`define KBS_IDX_W 8
`define KBS_IDX_ROW 3:0
`define KBS_IDX_COL 7:4

// Matrix geometry.
`define KBS_COLS 11
`define KBS_ROWS_BASE 8
`define KBS_ROWS_EXT 16
`define KBS_LAST_BASE 4'h7
`define KBS_LAST_EXT 4'hf

// Timing: clock period, velocity tick and row settle time.
`define KBS_CLK_NS 10
`define KBS_VEL_TICK_NS 64000
`define KBS_SETTLE_NS 2000
`define KBS_VEL_W 8

`endif

// file: src/kbscn_top.v
// Matrix scanner for keys, switches, LEDs and sliders with register port.
`timescale 1ns/100ps
`default_nettype none
`include "kbscn_consts.vh"
// What this block does
// - Mode high: both column groups read key contacts.
// - Mode low: read switches, drive LED columns on rows 0 to 7 only.
// - One row select addresses keys, switches, sliders.
// - Eight rows by eleven columns, eight sliders; sixteen switch and slider rows with the fourth row bit on.
// - First contact polarity: NC/NO, anode/cathode.
// - Second contact polarity: anode or cathode.
// - Slider converter samples channel of current row.
module kbscn_top #(
  parameter COLS = `KBS_COLS,
  parameter ADC_W = 10,
  parameter VEL_TICK_CYC = `KBS_VEL_TICK_NS / `KBS_CLK_NS,
  parameter SETTLE_CYC = `KBS_SETTLE_NS / `KBS_CLK_NS
) (
  input wire mclk_i,
  input wire arst_n_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output wire irq_o,
  output reg scan_mode_select_o,
  output wire [2:0] scan_line_select_o,
  output wire fourth_scan_line_bit_o,
  output wire fourth_scan_line_en_o,
  input wire [COLS-1:0] first_contact_column_i,
  input wire [COLS-1:0] second_contact_led_column_i,
  output reg [COLS-1:0] second_contact_led_column_o,
  output reg second_contact_led_column_oe_n_o,
  output reg slider_conv_start_o,
  input wire slider_conv_done_i,
  input wire [ADC_W-1:0] slider_conv_data_i
);

  localparam ST_IDLE = 5'h01;
  localparam ST_KSET = 5'h02;
  localparam ST_SSET = 5'h04;
  localparam ST_CONV = 5'h08;
  localparam ST_NEXT = 5'h10;
  localparam [15:0] SETTLE = SETTLE_CYC;
  localparam [15:0] VTICK = VEL_TICK_CYC;
  localparam VW = `KBS_VEL_W;

  reg [`KBS_CTRL_W-1:0] ctrl_r;
  reg [`KBS_EV_W-1:0] stat_r;
  reg [`KBS_EV_W-1:0] mask_r;
  reg [`KBS_IDX_W-1:0] index_r;
  reg [4:0] state_r;
  reg [3:0] row_r;
  reg [15:0] cnt_r;
  reg [15:0] vdiv_r;
  reg [VW-1:0] vtime_r;
  reg [`KBS_ROWS_BASE-1:0] kseen_r;
  reg [`KBS_ROWS_EXT-1:0] sseen_r;
  reg [COLS-1:0] br_m_r;
  reg [COLS-1:0] br_s_r;
  reg [COLS-1:0] mk_m_r;
  reg [COLS-1:0] mk_s_r;
  reg [COLS-1:0] sw_mem [0:`KBS_ROWS_EXT-1];
  reg [COLS-1:0] led_mem [0:`KBS_ROWS_BASE-1];
  reg [COLS-1:0] fc_mem [0:`KBS_ROWS_BASE-1];
  reg [COLS-1:0] on_mem [0:`KBS_ROWS_BASE-1];
  reg [ADC_W-1:0] sld_mem [0:`KBS_ROWS_EXT-1];
  reg [31:0] rd_nxt;
  reg [`KBS_EV_W-1:0] ev_nxt;
  wire [COLS*VW-1:0] vel_rd;
  wire [COLS-1:0] br_lvl;
  wire [COLS-1:0] mk_lvl;
  wire [COLS-1:0] fc_old;
  wire [COLS-1:0] on_old;
  wire [COLS-1:0] on_new;
  wire [COLS-1:0] sw_old;
  wire row_key;
  wire last_row;
  wire key_smp;
  wire sw_smp;
  wire vtick;
  wire en;
  wire ext;
  wire [3:0] rd_row;
  wire [3:0] rd_col;

  assign en = ctrl_r[`KBS_C_EN];
  assign ext = ctrl_r[`KBS_C_ROW4];
  assign rd_row = index_r[`KBS_IDX_ROW];
  assign rd_col = index_r[`KBS_IDX_COL];

  // The same row lines steer keys, switches, LEDs and the slider mux.
  assign scan_line_select_o = row_r[2:0];
  assign fourth_scan_line_bit_o = ext & row_r[3];
  assign fourth_scan_line_en_o = ext;

  // Rows 8 and up exist only for switches and sliders.
  assign row_key = ~row_r[3];
  assign last_row = ext ? (row_r == `KBS_LAST_EXT) : (row_r == `KBS_LAST_BASE);
  assign key_smp = state_r[2'd1] & (cnt_r == 16'h0000);
  assign sw_smp = state_r[2'd2] & (cnt_r == 16'h0000);

  // Two-stage synchronisers; the columns come straight from the matrix.
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      br_m_r <= {COLS{1'b0}};
      br_s_r <= {COLS{1'b0}};
      mk_m_r <= {COLS{1'b0}};
      mk_s_r <= {COLS{1'b0}};
    end
    else
    begin
      br_m_r <= first_contact_column_i;
      br_s_r <= br_m_r;
      mk_m_r <= second_contact_led_column_i;
      mk_s_r <= mk_m_r;
    end
  end

  // Contact closed means one after polarity correction.
  assign br_lvl = br_s_r ^ {COLS{ctrl_r[`KBS_C_BRNC] ^ ctrl_r[`KBS_C_BRCC]}};
  assign mk_lvl = mk_s_r ^ {COLS{ctrl_r[`KBS_C_MKCC]}};

  assign fc_old = kseen_r[row_r[2:0]] ? fc_mem[row_r[2:0]] : {COLS{1'b0}};
  assign on_old = kseen_r[row_r[2:0]] ? on_mem[row_r[2:0]] : {COLS{1'b0}};
  assign sw_old = sseen_r[row_r] ? sw_mem[row_r] : {COLS{1'b0}};
  // A key stays on until its first contact opens again.
  assign on_new = mk_lvl | (on_old & br_lvl);

  // Velocity time base: one enable pulse per tick of the key timer.
  assign vtick = (vdiv_r == 16'h0000);
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      vdiv_r <= 16'h0000;
      vtime_r <= {VW{1'b0}};
    end
    else if (vtick)
    begin
      vdiv_r <= VTICK - 16'h0001;
      vtime_r <= vtime_r + 1'b1;
    end
    else
    begin
      vdiv_r <= vdiv_r - 16'h0001;
    end
  end

  // Per-column key timers. Each column keeps its own arrays so that every
  // memory has a single writer.
  genvar gc;
  generate
    for (gc = 0; gc < COLS; gc = gc + 1)
    begin : g_col
      reg [VW-1:0] t1_mem [0:`KBS_ROWS_BASE-1];
      reg [VW-1:0] vel_mem [0:`KBS_ROWS_BASE-1];
      wire [VW-1:0] dt;
      assign dt = vtime_r - t1_mem[row_r[2:0]];
      always @(posedge mclk_i)
      begin
        if (key_smp & row_key & br_lvl[gc] & ~fc_old[gc])
          t1_mem[row_r[2:0]] <= vtime_r;
        if (key_smp & row_key & mk_lvl[gc] & ~on_old[gc])
          vel_mem[row_r[2:0]] <= (br_lvl[gc] & ~fc_old[gc]) ? {VW{1'b0}} : dt;
      end
      assign vel_rd[gc*VW +: VW] = vel_mem[rd_row[2:0]];
    end
  endgenerate

  // Row sequencer: key phase, then switch/LED phase and slider conversion.
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_IDLE;
      row_r <= 4'h0;
      cnt_r <= 16'h0000;
      scan_mode_select_o <= 1'b0;
      second_contact_led_column_o <= {COLS{1'b0}};
      second_contact_led_column_oe_n_o <= 1'b1;
      slider_conv_start_o <= 1'b0;
    end
    else
    begin
      slider_conv_start_o <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          second_contact_led_column_oe_n_o <= 1'b1;
          row_r <= 4'h0;
          if (en)
          begin
            state_r <= ST_KSET;
            scan_mode_select_o <= 1'b1;
            cnt_r <= SETTLE;
          end
        end
        ST_KSET:
        begin
          if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
          else
          begin
            // Leave key mode in the same cycle that drives LEDs onto the shared columns.
            state_r <= ST_SSET;
            scan_mode_select_o <= 1'b0;
            second_contact_led_column_o <= led_mem[row_r[2:0]];
            second_contact_led_column_oe_n_o <= 1'b0;
            cnt_r <= SETTLE;
          end
        end
        ST_SSET:
        begin
          if (cnt_r != 16'h0000)
            cnt_r <= cnt_r - 16'h0001;
          else
          begin
            state_r <= ST_CONV;
            slider_conv_start_o <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (slider_conv_done_i)
            state_r <= ST_NEXT;
        end
        ST_NEXT:
        begin
          row_r <= last_row ? 4'h0 : row_r + 4'h1;
          // LEDs release with the row change, also when scanning stops here.
          second_contact_led_column_oe_n_o <= 1'b1;
          cnt_r <= SETTLE;
          if (!en)
            state_r <= ST_IDLE;
          else if (last_row | (~row_r[3] & (row_r[2:0] != 3'h7)))
          begin
            // Next row is a key row unless it lies in the upper eight.
            state_r <= ST_KSET;
            scan_mode_select_o <= 1'b1;
          end
          else
            state_r <= ST_SSET;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Sample stores for keys, switches and sliders.
  always @(posedge mclk_i)
  begin
    if (key_smp & row_key)
    begin
      fc_mem[row_r[2:0]] <= br_lvl;
      on_mem[row_r[2:0]] <= on_new;
    end
    if (sw_smp)
      sw_mem[row_r] <= br_s_r;
    if (state_r[2'd3] & slider_conv_done_i)
      sld_mem[row_r] <= slider_conv_data_i;
    if (reg_wr_i & (reg_addr_i == `KBS_A_LED))
      led_mem[rd_row[2:0]] <= reg_wdata_i[COLS-1:0];
  end

  // Row memories hold garbage after power-up, so a row's first sample is
  // judged against all-open contacts instead of its stored copy.
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      kseen_r <= {`KBS_ROWS_BASE{1'b0}};
      sseen_r <= {`KBS_ROWS_EXT{1'b0}};
    end
    else
    begin
      if (key_smp & row_key)
        kseen_r[row_r[2:0]] <= 1'b1;
      if (sw_smp)
        sseen_r[row_r] <= 1'b1;
    end
  end

  // Events of this cycle; a key or switch is only judged once sampled.
  always @*
  begin
    ev_nxt = `KBS_EV_RST;
    ev_nxt[`KBS_EV_KON] = key_smp & row_key & |(mk_lvl & ~on_old);
    ev_nxt[`KBS_EV_KOFF] = key_smp & row_key & |(on_old & ~on_new);
    ev_nxt[`KBS_EV_SW] = sw_smp & (sw_old != br_s_r);
    ev_nxt[`KBS_EV_FRM] = state_r[3'd4] & last_row;
  end

  // Control, mask, index and sticky status; a new event beats a clear.
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r <= `KBS_CTRL_RST;
      mask_r <= `KBS_EV_RST;
      stat_r <= `KBS_EV_RST;
      index_r <= {`KBS_IDX_W{1'b0}};
    end
    else
    begin
      if (reg_wr_i & (reg_addr_i == `KBS_A_CTRL))
        ctrl_r <= reg_wdata_i[`KBS_CTRL_W-1:0];
      if (reg_wr_i & (reg_addr_i == `KBS_A_MASK))
        mask_r <= reg_wdata_i[`KBS_EV_W-1:0];
      if (reg_wr_i & (reg_addr_i == `KBS_A_INDEX))
        index_r <= reg_wdata_i[`KBS_IDX_W-1:0];
      if (reg_wr_i & (reg_addr_i == `KBS_A_STAT))
        stat_r <= (stat_r & ~reg_wdata_i[`KBS_EV_W-1:0]) | ev_nxt;
      else
        stat_r <= stat_r | ev_nxt;
    end
  end

  assign irq_o = |(stat_r & mask_r);

  // Read mux; unmapped addresses and out-of-range columns read zero.
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr_i)
      `KBS_A_CTRL: rd_nxt[`KBS_CTRL_W-1:0] = ctrl_r;
      `KBS_A_STAT: rd_nxt[`KBS_EV_W-1:0] = stat_r;
      `KBS_A_MASK: rd_nxt[`KBS_EV_W-1:0] = mask_r;
      `KBS_A_INDEX: rd_nxt[`KBS_IDX_W-1:0] = index_r;
      `KBS_A_SW: rd_nxt[COLS-1:0] = sw_mem[rd_row];
      `KBS_A_LED: rd_nxt[COLS-1:0] = led_mem[rd_row[2:0]];
      `KBS_A_KEYS: rd_nxt[COLS-1:0] = on_mem[rd_row[2:0]];
      `KBS_A_VEL:
      begin
        if (rd_col < COLS)
          rd_nxt[VW-1:0] = vel_rd[rd_col*VW +: VW];
      end
      `KBS_A_SLD: rd_nxt[ADC_W-1:0] = sld_mem[rd_row];
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
      reg_rdata_o <= rd_nxt;
    else
      reg_rdata_o <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

// file: test/kbscn_monitor.sv
// Port-level assertions for the matrix scanner.
`timescale 1ns/100ps
`default_nettype none
module kbscn_monitor (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic scan_mode_select_o,
  input wire logic [2:0] scan_line_select_o,
  input wire logic fourth_scan_line_bit_o,
  input wire logic fourth_scan_line_en_o,
  input wire logic second_contact_led_column_oe_n_o,
  input wire logic slider_conv_start_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_key;
    scan_mode_select_o [*5];
  endsequence
  sequence s_led;
    (!scan_mode_select_o && !second_contact_led_column_oe_n_o) [*5];
  endsequence
  property p_key_seq;
    $rose(scan_mode_select_o) |-> s_key ##1 s_led;
  endproperty
  a_key_seq: assert property (p_key_seq) else $error("key then led phase wrong");
  property p_led_start;
    $fell(second_contact_led_column_oe_n_o) |-> ##[5:8] slider_conv_start_o;
  endproperty
  a_led_start: assert property (p_led_start) else $error("no slider start");
  property p_drive_mode;
    !second_contact_led_column_oe_n_o |-> !scan_mode_select_o;
  endproperty
  a_drive_mode: assert property (p_drive_mode) else $error("led drive in key mode");
  property p_ext_bit;
    !fourth_scan_line_en_o |-> !fourth_scan_line_bit_o;
  endproperty
  a_ext_bit: assert property (p_ext_bit) else $error("fourth bit while off");
  property p_ext_noled;
    fourth_scan_line_bit_o |-> second_contact_led_column_oe_n_o;
  endproperty
  a_ext_noled: assert property (p_ext_noled) else $error("led drive on upper row");
  property p_row_step;
    $changed(scan_line_select_o) |->
      scan_line_select_o == $past(scan_line_select_o) + 3'd1 || scan_line_select_o == 3'd0;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row skipped");
  property p_row_hold;
    slider_conv_start_o |=> $stable(scan_line_select_o) && !scan_mode_select_o;
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row moved in conversion");
  property p_start_pulse;
    slider_conv_start_o |=> !slider_conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
endmodule
bind kbscn_top kbscn_monitor kbscn_monitor_i (.mclk_i, .arst_n_i, .scan_mode_select_o,
  .scan_line_select_o, .fourth_scan_line_bit_o, .fourth_scan_line_en_o,
  .second_contact_led_column_oe_n_o, .slider_conv_start_o);
`default_nettype wire

// file: test/kbscn_matrix_model.sv
// Keyboard, switch, LED and slider matrix seen from the scanner pins.
`timescale 1ns/100ps
`default_nettype none
module kbscn_matrix_model (
  input wire logic mclk_i,
  input wire logic scan_mode_select_o,
  input wire logic [2:0] scan_line_select_o,
  input wire logic fourth_scan_line_bit_o,
  input wire logic [10:0] second_contact_led_column_o,
  input wire logic second_contact_led_column_oe_n_o,
  input wire logic slider_conv_start_o,
  input wire logic [3:0] key_row_i,
  input wire logic [10:0] key_cols_i,
  input wire logic [6:0] salt_i,
  input wire logic [7:0] conv_wait_i,
  input wire logic late_i,
  input wire logic [1:0] inv_i,
  output logic [10:0] first_contact_column_i,
  output logic [10:0] second_contact_led_column_i,
  output logic slider_conv_done_i,
  output logic [9:0] slider_conv_data_i,
  output logic [10:0] led_row5_o
);
  logic [3:0] row;
  logic [10:0] keys;
  logic [10:0] keys2;
  logic [7:0] cnt = 8'd0;
  assign row = {fourth_scan_line_bit_o, scan_line_select_o};
  assign keys = (row == key_row_i) ? key_cols_i : 11'h0;
  // A held-back second contact lets the key timer run between the two closures.
  assign keys2 = late_i ? 11'h0 : keys;
  // Spring contacts read low when closed; cathode wiring flips the second column.
  assign first_contact_column_i = scan_mode_select_o ?
    keys ^ {11{inv_i[0]}} : {salt_i, row};
  // Undriven lines show the inverse of the LED word so a stale copy cannot pass.
  assign second_contact_led_column_i = !second_contact_led_column_oe_n_o ?
    second_contact_led_column_o :
    (scan_mode_select_o ? keys2 ^ {11{inv_i[1]}} : ~second_contact_led_column_o);
  assign slider_conv_data_i = {salt_i[5:0], row};
  assign slider_conv_done_i = (cnt == 8'd1);
  always @(posedge mclk_i)
  begin
    if (slider_conv_start_o)
      cnt <= conv_wait_i + 8'd1;
    else if (cnt != 8'd0)
      cnt <= cnt - 8'd1;
    if (!second_contact_led_column_oe_n_o && row == 4'd5)
      led_row5_o <= second_contact_led_column_o;
  end
endmodule
`default_nettype wire

// file: test/kbscn_top_tb.sv
// Self-checking bench for the matrix scanner.
`timescale 1ns/100ps
`default_nettype none
`include "kbscn_consts.vh"
module kbscn_top_tb;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o, scan_mode_select_o, fourth_scan_line_bit_o, fourth_scan_line_en_o;
  logic [2:0] scan_line_select_o;
  logic [10:0] first_contact_column_i, second_contact_led_column_i;
  logic [10:0] second_contact_led_column_o, led_row5_o;
  logic second_contact_led_column_oe_n_o, slider_conv_start_o, slider_conv_done_i;
  logic [9:0] slider_conv_data_i;
  logic [3:0] key_row_i = 4'h2;
  logic [10:0] key_cols_i = 11'h0;
  logic [6:0] salt_i = 7'h0;
  logic [7:0] conv_wait_i = 8'h0;
  logic late_i = 1'b0;
  logic [1:0] inv_i = 2'b00;
  localparam int VTICK = 4;
  time t1;
  int dcyc;
  logic [31:0] seed = 32'h7a361a6f;
  logic [31:0] q;
  int mismatches = 0;
  int tests_run = 0;
  int led_q[$];
  kbscn_top #(.VEL_TICK_CYC(VTICK), .SETTLE_CYC(4)) kbscn_top_i (.*);
  kbscn_matrix_model kbscn_matrix_model_i (.*);
  initial forever #5 mclk_i = ~mclk_i;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    q = reg_rdata_o;
    chk(q, exp);
  endtask
  // Returns on the rising edge after the scan enters row r anew.
  task automatic wait_row(input logic [2:0] r);
    do @(negedge mclk_i); while (scan_line_select_o == r);
    do @(negedge mclk_i); while (scan_line_select_o != r);
    @(posedge mclk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge mclk_i);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rdc(`KBS_A_CTRL, 32'h0);
    rdc(8'h3c, 32'h0);
    for (int r = 0; r < 8; r++)
    begin
      seed = xs(seed);
      led_q.push_back(seed[10:0]);
      wr(`KBS_A_INDEX, r);
      wr(`KBS_A_LED, seed[10:0]);
    end
    salt_i <= seed[17:11];
    key_cols_i <= seed[28:18] | 11'h1;
    wr(`KBS_A_CTRL, 32'h1);
    repeat (400) @(posedge mclk_i);
    chk(led_row5_o, led_q[5]);
    for (int r = 0; r < 8; r++)
    begin
      wr(`KBS_A_INDEX, r);
      rdc(`KBS_A_SW, {salt_i, r[3:0]});
      rdc(`KBS_A_SLD, {salt_i[5:0], r[3:0]});
      rdc(`KBS_A_KEYS, (r == 2) ? key_cols_i : 11'h0);
      rdc(`KBS_A_LED, led_q[r]);
    end
    wr(`KBS_A_INDEX, 32'h02);
    rdc(`KBS_A_VEL, 32'h0);
    // Release, then close the first contact one frame before the second.
    wait_row(3'd3);
    key_cols_i <= 11'h0;
    wait_row(3'd3);
    rdc(`KBS_A_STAT, 32'hf);
    wait_row(3'd3);
    late_i <= 1'b1;
    key_cols_i <= 11'h1;
    wait_row(3'd3);
    t1 = $time;
    late_i <= 1'b0;
    wait_row(3'd3);
    dcyc = int'(($time - t1) / `KBS_CLK_NS);
    rdc(`KBS_A_VEL, (dcyc / VTICK) % (1 << `KBS_VEL_W));
    wr(`KBS_A_MASK, 32'h8);
    rdc(`KBS_A_MASK, 32'h8);
    @(posedge mclk_i);
    #1;
    chk(reg_rdata_o, 32'h0);
    chk({31'h0, irq_o}, 32'h1);
    wr(`KBS_A_CTRL, 32'h0);
    repeat (100) @(posedge mclk_i);
    wr(`KBS_A_STAT, 32'hf);
    rdc(`KBS_A_STAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    seed = xs(seed);
    salt_i <= seed[6:0];
    conv_wait_i <= 8'd20;
    wr(`KBS_A_CTRL, 32'h3);
    repeat (1500) @(posedge mclk_i);
    for (int r = 8; r < 16; r++)
    begin
      wr(`KBS_A_INDEX, r);
      rdc(`KBS_A_SW, {salt_i, r[3:0]});
      rdc(`KBS_A_SLD, {salt_i[5:0], r[3:0]});
    end
    // Spring contacts and cathode wiring must still give the same key state.
    wr(`KBS_A_CTRL, 32'h0);
    repeat (100) @(posedge mclk_i);
    inv_i <= 2'b11;
    wr(`KBS_A_CTRL, 32'h15);
    repeat (400) @(posedge mclk_i);
    for (int r = 0; r < 8; r++)
    begin
      wr(`KBS_A_INDEX, r);
      rdc(`KBS_A_KEYS, (r == 2) ? 11'h1 : 11'h0);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
